/* File: shared/patr_pkg.sv */
// Package for the power table and ramp control block.
// Assumes a single 250 MHz clock and a plain register port.
package patr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // Register offsets
    localparam logic [7:0] ADDR_POWER_TABLE = 8'h00;
    localparam logic [7:0] ADDR_FRONT_END_TX_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_GP_OUT_CONFIG_REG = 8'h02;
    localparam logic [7:0] ADDR_SYNTH_CAL_WORD_ONE = 8'h03;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    // Field positions in the tx config register
    localparam int unsigned TOP_INDEX_LSB = 0;
    localparam int unsigned MOD_LSB = 4;
    // Status field positions
    localparam int unsigned ST_LOCK = 0;
    localparam int unsigned ST_SLEEP = 1;
    localparam int unsigned ST_TX = 2;
    // Reset and special values
    localparam logic [7:0] POWER_TABLE_RST = 8'hC6;
    localparam logic [7:0] FORBID_LO = 8'h61;
    localparam logic [7:0] FORBID_HI = 8'h6F;
    localparam logic [5:0] GP_SEL_LOCK = 6'h0A;
    localparam logic [5:0] GP_SEL_RST = 6'h00;
    localparam logic [5:0] CAL_UNLOCKED = 6'h3F;
    localparam logic [7:0] TX_CONFIG_RST = 8'h00;
    // Shaping counter runs at eight times the symbol rate
    localparam int unsigned SHAPE_PER_SYMBOL = 8;
    localparam logic [15:0] SYM_DIV_RST = 16'h0010;
    // Modulation modes
    typedef enum logic [1:0] {
        PATR_MOD_FSK = 2'h0,
        PATR_MOD_OOK = 2'h1,
        PATR_MOD_ASK = 2'h2
    } patr_mod_t;
endpackage

/* File: core/patr_power_table.sv */
// Power level table storage, eight entries of flip-flops.
// Assumes the caller decodes burst and single writes.
`timescale 1ns/100ps
`default_nettype none
module patr_power_table #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Write port
    input wire logic wr_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Sleep entry loses upper entries
    input wire logic sleep_enter_i,
    // Read ports
    input wire logic [$clog2(DEPTH)-1:0] tx_idx_i,
    output logic [WIDTH-1:0] tx_level_o,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
    output logic [WIDTH-1:0] rd_data_o
);
    initial begin
        if (DEPTH != 8 || WIDTH != 8) $error("patr_power_table: DEPTH and WIDTH must be 8");
    end
    logic [WIDTH-1:0] entry_r [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    entry_r[g] <= patr_pkg::POWER_TABLE_RST;
                end else if (ce_i) begin
                    if (sleep_enter_i && g != 0) begin
                        entry_r[g] <= patr_pkg::POWER_TABLE_RST;
                    end else if (wr_i && wr_idx_i == g) begin
                        entry_r[g] <= wr_data_i;
                    end
                end
            end
        end
    endgenerate
    assign tx_level_o = entry_r[tx_idx_i];
    assign rd_data_o = entry_r[rd_idx_i];
endmodule
`default_nettype wire

/* File: core/patr_shaper.sv */
// Shaping counter stepping the table index for ramps and keying.
// Assumes a symbol tick from the parent.
`timescale 1ns/100ps
`default_nettype none
module patr_shaper #(
    parameter int IDX_W = 3
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Control
    input wire logic step_i,
    input wire logic up_i,
    input wire logic [IDX_W-1:0] top_i,
    // Index out
    output logic [IDX_W-1:0] idx_o
);
    initial begin
        if (IDX_W < 1) $error("patr_shaper: IDX_W must be positive");
    end
    logic [IDX_W-1:0] idx_r;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idx_r <= '0;
        end else if (ce_i && step_i) begin
            // Saturate at the top index and at zero
            if (up_i && idx_r < top_i) begin
                idx_r <= idx_r + 1'b1;
            end else if (up_i && idx_r > top_i) begin
                idx_r <= top_i;
            end else if (!up_i && idx_r != '0) begin
                idx_r <= idx_r - 1'b1;
            end
        end
    end
    assign idx_o = idx_r;
endmodule
`default_nettype wire

/* File: core/patr_ctrl.sv */
// Top of the power table and ramp control block.
// Assumes the host drives a plain synchronous register port and radio status inputs.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Eight-entry table; 3-bit top index selects the transmit power entry.
// - Ramps and shaping step through entries from 0 to top index.
// - In on-off keying, in the on state zero uses entry 0, one uses entry 1; ramps use the ramp index.
// - Table entries reset to 0xC6.
// - Single writes reach entry 0 only; burst writes reach others.
// - Sleep keeps entry 0 and loses all other entries.
// - Calibration word survives sleep.
// - Output select 0x0A routes PLL lock to general output.
// - Calibration register reads 0x3F while the PLL is unlocked outside sleep.
// - After power-down strobe, power drops when select returns high.
// - Select going low while powered down restores power and oscillator.
// - ASK counter at eight times symbol rate, saturating at top and zero.
// - Counter value indexes the table for instantaneous power.
module patr_ctrl #(
    parameter int DIV_W = 16
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_burst_i,
    output logic [7:0] reg_rdata_o,
    // Serial select and power-down strobe
    input wire logic serial_select_n_i,
    input wire logic power_down_strobe_i,
    output logic core_power_on_o,
    output logic xosc_enable_o,
    // Sleep request from the radio state machine
    input wire logic sleep_req_i,
    // Transmit control
    input wire logic tx_start_i,
    input wire logic tx_end_i,
    input wire logic tx_bit_i,
    output logic tx_active_o,
    output logic [7:0] pa_level_o,
    // Synthesizer
    input wire logic pll_lock_i,
    input wire logic cal_done_i,
    input wire logic [5:0] cal_value_i,
    // General purpose output
    input wire logic [7:0] gp_other_i,
    output logic gp_output_pin_o
);
    initial begin
        if (DIV_W < 4 || DIV_W > 16) $error("patr_ctrl: DIV_W must be 4 to 16");
    end

    typedef enum logic [3:0] {
        PATR_IDLE = 4'b0001,
        PATR_RAMP_UP = 4'b0010,
        PATR_ON = 4'b0100,
        PATR_RAMP_DN = 4'b1000
    } patr_state_t;

    logic [7:0] front_end_tx_config_r;
    logic [7:0] gp_out_config_reg_r;
    logic [5:0] synth_cal_r;
    logic [DIV_W-1:0] sym_div_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic [2:0] burst_idx_r;
    logic burst_active_r;
    logic pd_armed_r;
    logic powered_r;
    logic sleep_r;
    logic lock_r;
    logic gp_r;
    logic [7:0] pa_level_r;
    logic [7:0] rdata_r;
    patr_state_t state_r;
    patr_state_t state_nxt;

    logic [2:0] top_idx;
    logic [1:0] mode;
    logic tick;
    logic shape_step;
    logic shape_up;
    logic [2:0] shape_idx;
    logic [2:0] tx_idx;
    logic [7:0] tx_level;
    logic [7:0] tbl_rd;
    logic tbl_wr;
    logic [2:0] tbl_idx;
    logic sleep_enter;
    logic [5:0] gp_sel;

    assign top_idx = front_end_tx_config_r[patr_pkg::TOP_INDEX_LSB +: 3];
    assign mode = front_end_tx_config_r[patr_pkg::MOD_LSB +: 2];
    assign gp_sel = gp_out_config_reg_r[5:0];
    assign sleep_enter = sleep_req_i && !sleep_r;

    // Table write decode
    assign tbl_wr = reg_wr_i && reg_addr_i == patr_pkg::ADDR_POWER_TABLE;
    // A write outside a burst always lands in entry 0
    assign tbl_idx = (reg_burst_i && burst_active_r) ? burst_idx_r : 3'h0;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            burst_idx_r <= 3'h0;
            burst_active_r <= 1'b0;
        end else if (ce_i) begin
            if (!reg_burst_i) begin
                burst_idx_r <= 3'h0;
                burst_active_r <= 1'b0;
            end else if (tbl_wr) begin
                burst_active_r <= 1'b1;
                burst_idx_r <= tbl_idx + 3'h1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            front_end_tx_config_r <= patr_pkg::TX_CONFIG_RST;
            gp_out_config_reg_r <= {2'h0, patr_pkg::GP_SEL_RST};
            sym_div_r <= DIV_W'(patr_pkg::SYM_DIV_RST);
        end else if (ce_i && reg_wr_i) begin
            unique case (reg_addr_i)
                patr_pkg::ADDR_FRONT_END_TX_CONFIG: front_end_tx_config_r <= reg_wdata_i;
                patr_pkg::ADDR_GP_OUT_CONFIG_REG: gp_out_config_reg_r <= reg_wdata_i;
                patr_pkg::ADDR_TX_CTRL: sym_div_r <= DIV_W'(reg_wdata_i);
                default: ;
            endcase
        end
    end

    // Calibration word is held across sleep, not cleared by it
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            synth_cal_r <= patr_pkg::CAL_UNLOCKED;
            lock_r <= 1'b0;
        end else if (ce_i) begin
            lock_r <= pll_lock_i;
            if (cal_done_i) begin
                synth_cal_r <= pll_lock_i ? cal_value_i : patr_pkg::CAL_UNLOCKED;
            end else if (!pll_lock_i && !sleep_r) begin
                synth_cal_r <= patr_pkg::CAL_UNLOCKED;
            end
        end
    end

    // Power-down: armed by the strobe, power drops only when select is high
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pd_armed_r <= 1'b0;
            powered_r <= 1'b1;
            sleep_r <= 1'b0;
        end else if (ce_i) begin
            if (!powered_r) begin
                if (!serial_select_n_i) begin
                    powered_r <= 1'b1;
                    sleep_r <= 1'b0;
                end
            end else if (pd_armed_r && serial_select_n_i) begin
                powered_r <= 1'b0;
                pd_armed_r <= 1'b0;
                sleep_r <= 1'b1;
            end else if (power_down_strobe_i) begin
                pd_armed_r <= 1'b1;
            end else if (sleep_enter) begin
                sleep_r <= 1'b1;
            end else if (!sleep_req_i && serial_select_n_i) begin
                sleep_r <= sleep_r;
            end else if (!sleep_req_i) begin
                sleep_r <= 1'b0;
            end
        end
    end

    // Symbol tick at eight times the symbol rate
    assign tick = div_cnt_r == '0;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt_r <= '0;
        end else if (ce_i) begin
            div_cnt_r <= tick ? sym_div_r : div_cnt_r - 1'b1;
        end
    end

    // Packet ramp sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PATR_IDLE: if (tx_start_i) state_nxt = PATR_RAMP_UP;
            PATR_RAMP_UP: if (shape_idx == top_idx) state_nxt = PATR_ON;
            PATR_ON: if (tx_end_i) state_nxt = PATR_RAMP_DN;
            PATR_RAMP_DN: if (shape_idx == 3'h0) state_nxt = PATR_IDLE;
            default: state_nxt = PATR_IDLE;
        endcase
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= PATR_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    // Ramp up toward top, or follow data bits in ASK, else ramp down
    assign shape_step = tick && state_r != PATR_IDLE;
    always_comb begin
        shape_up = 1'b0;
        unique case (state_r)
            PATR_RAMP_UP: shape_up = 1'b1;
            PATR_ON: shape_up = mode == patr_pkg::PATR_MOD_ASK ? tx_bit_i : 1'b1;
            default: shape_up = 1'b0;
        endcase
    end

    patr_shaper #(
        .IDX_W(3)
    ) u_shaper (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .step_i(shape_step),
        .up_i(shape_up),
        .top_i(top_idx),
        .idx_o(shape_idx)
    );

    // In the on state, on-off keying picks entry 0 or 1 per bit instead of the ramp index
    assign tx_idx = (mode == patr_pkg::PATR_MOD_OOK && state_r == PATR_ON) ?
        {2'h0, tx_bit_i} : shape_idx;

    patr_power_table #(
        .DEPTH(8),
        .WIDTH(8)
    ) u_table (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .wr_i(tbl_wr),
        .wr_idx_i(tbl_idx),
        .wr_data_i(reg_wdata_i),
        .sleep_enter_i(sleep_enter || (pd_armed_r && serial_select_n_i && powered_r)),
        .tx_idx_i(tx_idx),
        .tx_level_o(tx_level),
        .rd_idx_i(3'h0),
        .rd_data_o(tbl_rd)
    );

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pa_level_r <= 8'h00;
        end else if (ce_i) begin
            pa_level_r <= state_r == PATR_IDLE ? 8'h00 : tx_level;
        end
    end

    // General output: lock detector on select 0x0A, else a status bit
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gp_r <= 1'b0;
        end else if (ce_i) begin
            gp_r <= gp_sel == patr_pkg::GP_SEL_LOCK ? lock_r : gp_other_i[gp_sel[2:0]];
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
        end else if (ce_i) begin
            rdata_r <= 8'h00;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    patr_pkg::ADDR_POWER_TABLE: rdata_r <= tbl_rd;
                    patr_pkg::ADDR_FRONT_END_TX_CONFIG: rdata_r <= front_end_tx_config_r;
                    patr_pkg::ADDR_GP_OUT_CONFIG_REG: rdata_r <= gp_out_config_reg_r;
                    patr_pkg::ADDR_SYNTH_CAL_WORD_ONE: rdata_r <= {2'h0, synth_cal_r};
                    patr_pkg::ADDR_TX_CTRL: rdata_r <= 8'(sym_div_r);
                    patr_pkg::ADDR_STATUS: rdata_r <= {5'h00, state_r != PATR_IDLE,
                        sleep_r, lock_r};
                    default: rdata_r <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata_o = rdata_r;
    assign pa_level_o = pa_level_r;
    assign gp_output_pin_o = gp_r;
    assign core_power_on_o = powered_r;
    assign xosc_enable_o = powered_r;
    assign tx_active_o = state_r != PATR_IDLE;
endmodule
`default_nettype wire

/* File: test/patr_ctrl_chk.sv */
// Concurrent checks on the ports of the power table and ramp control top.
// Assumes a bind onto patr_ctrl with ce_i held high by the bench.
`timescale 1ns/100ps
`default_nettype none
module patr_ctrl_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Observed ports
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic serial_select_n_i,
    input wire logic power_down_strobe_i,
    input wire logic core_power_on_o,
    input wire logic xosc_enable_o,
    input wire logic tx_start_i,
    input wire logic tx_active_o,
    input wire logic [7:0] pa_level_o,
    input wire logic pll_lock_i,
    input wire logic cal_done_i,
    input wire logic gp_output_pin_o
);
    logic [5:0] sel_r;
    logic armed_r;
    logic cal_bad_r;
    logic tbl_wr_r;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Shadows rebuilt from port traffic, so no peeking into the body
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_r <= patr_pkg::GP_SEL_RST;
            tbl_wr_r <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == patr_pkg::ADDR_GP_OUT_CONFIG_REG) sel_r <= reg_wdata_i[5:0];
            if (reg_addr_i == patr_pkg::ADDR_POWER_TABLE) tbl_wr_r <= 1'b1;
        end
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) armed_r <= 1'b0;
        else if (power_down_strobe_i) armed_r <= 1'b1;
        else if (!core_power_on_o) armed_r <= 1'b0;
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) cal_bad_r <= 1'b0;
        else if (cal_done_i) cal_bad_r <= !pll_lock_i;
    end
    a_table_default: assert property (reg_rd_i && reg_addr_i == 8'h00 && !tbl_wr_r |=>
        reg_rdata_o == patr_pkg::POWER_TABLE_RST) else $error("table default wrong");
    a_cal_unlocked: assert property (reg_rd_i && reg_addr_i == 8'h03 && cal_bad_r |=>
        reg_rdata_o == 8'h3F) else $error("unlocked cal code wrong");
    a_gp_lock: assert property (sel_r == patr_pkg::GP_SEL_LOCK |=>
        gp_output_pin_o == $past(pll_lock_i, 2)) else $error("lock not on output");
    a_pa_idle_zero: assert property (!tx_active_o && $past(!tx_active_o && !tx_start_i) |->
        pa_level_o == 8'h00) else $error("level while idle");
    a_power_held: assert property (core_power_on_o && !serial_select_n_i |=> core_power_on_o)
        else $error("power dropped while selected");
    a_power_drop: assert property (armed_r && serial_select_n_i |-> ##[0:4] !core_power_on_o)
        else $error("power not removed");
    a_power_wake: assert property (!core_power_on_o && !serial_select_n_i |-> ##[1:4]
        core_power_on_o) else $error("power not restored");
    a_osc_wake: assert property (!core_power_on_o && !serial_select_n_i |-> ##[1:4]
        xosc_enable_o) else $error("oscillator not restarted");
    c_tx: cover property ($rose(tx_active_o));
    c_drop: cover property ($fell(core_power_on_o));
    c_lock: cover property ($rose(gp_output_pin_o) && sel_r == patr_pkg::GP_SEL_LOCK);
endmodule
`default_nettype wire

/* File: test/patr_host.sv */
// Host controller model driving the register port of the block.
// Assumes the register port takes strobes on rising edges, read data one cycle later.
`timescale 1ns/100ps
`default_nettype none
module patr_host (
    // Clock
    input wire logic mclk_i,
    // Register port
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic reg_burst_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_burst_o = 1'b0;
    end
    // Burst stays up between writes; dropping it rewinds the table index
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
        logic [7:0] v;
        v = d;
        if (a == 8'h00 && d >= patr_pkg::FORBID_LO && d <= patr_pkg::FORBID_HI) v = 8'hC6;
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= v;
        reg_wr_o <= 1'b1;
        reg_burst_o <= b;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
    endtask
    task automatic end_burst();
        @(posedge mclk_i);
        reg_burst_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
    endtask
    // A first calibration may miss lock, so poll a bounded number of times
    task automatic cal_until_lock(output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int i = 0; i < 12 && !ok; i++) begin
            rd(8'h03, d);
            ok = (d !== 8'h3F);
        end
    endtask
endmodule
`default_nettype wire

/* File: test/power_table_top_index_table_ramp_control_test.sv */
// Self-checking bench for the power table and ramp control block.
// Assumes a 250 MHz clock and the host model on the register port.
`timescale 1ns/100ps
`default_nettype none
module power_table_top_index_table_ramp_control_test;
    logic mclk_i, resetn_i, reg_wr_i, reg_rd_i, reg_burst_i, serial_select_n_i;
    logic power_down_strobe_i, core_power_on_o, xosc_enable_o, sleep_req_i, tx_start_i;
    logic tx_end_i, tx_bit_i, tx_active_o, pll_lock_i, cal_done_i, gp_output_pin_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pa_level_o, gp_other_i;
    logic [5:0] cal_value_i;
    logic [7:0] tbl [8];
    logic [7:0] seen [$];
    logic ok;
    int fails = 0;
    int checks = 0;
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    patr_ctrl DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_burst_i(reg_burst_i), .reg_rdata_o(reg_rdata_o),
        .serial_select_n_i(serial_select_n_i), .power_down_strobe_i(power_down_strobe_i),
        .core_power_on_o(core_power_on_o), .xosc_enable_o(xosc_enable_o),
        .sleep_req_i(sleep_req_i), .tx_start_i(tx_start_i), .tx_end_i(tx_end_i),
        .tx_bit_i(tx_bit_i), .tx_active_o(tx_active_o), .pa_level_o(pa_level_o),
        .pll_lock_i(pll_lock_i), .cal_done_i(cal_done_i), .cal_value_i(cal_value_i),
        .gp_other_i(gp_other_i), .gp_output_pin_o(gp_output_pin_o));
    patr_host host (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_burst_o(reg_burst_i),
        .reg_rdata_i(reg_rdata_o));
    // Record each new level in use, so the ramp path is judged without cycle guesses
    always @(posedge mclk_i) begin
        #1;
        if (pa_level_o !== 8'h00 && (seen.size() == 0 || seen[$] !== pa_level_o))
            seen.push_back(pa_level_o);
    end
    task automatic print_verdict();
        if (fails == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic tx_stop();
        @(posedge mclk_i);
        tx_end_i <= 1'b1;
        @(posedge mclk_i);
        tx_end_i <= 1'b0;
        for (int i = 0; i < 400 && tx_active_o !== 1'b0; i++) @(posedge mclk_i);
        if (tx_active_o !== 1'b0) begin
            fails++;
            print_verdict();
        end
    endtask
    task automatic tx_go(input logic [1:0] m, input logic [2:0] top, input logic b);
        host.wr(8'h01, {2'b00, m, 1'b0, top}, 1'b0);
        seen.delete();
        tx_bit_i <= b;
        tx_start_i <= 1'b1;
        @(posedge mclk_i);
        tx_start_i <= 1'b0;
        cyc(80);
        chk("tx active", 8'h01, {7'h00, tx_active_o});
    endtask
    // FSK ramps and ASK ones-then-zeros both walk entry 0 to top and back
    task automatic t_ramp(input logic [1:0] m, input logic [2:0] top);
        logic [7:0] q [$];
        for (int i = 0; i <= top; i++) q.push_back(tbl[i]);
        for (int i = top - 1; i >= 0; i--) q.push_back(tbl[i]);
        tx_go(m, top, 1'b1);
        if (m == 2'h2) tx_bit_i <= 1'b0;
        cyc(80);
        tx_stop();
        chk("ramp steps", 8'(q.size()), 8'(seen.size()));
        for (int i = 0; i < q.size() && i < seen.size(); i++) chk("ramp level", q[i], seen[i]);
    endtask
    task automatic t_ook();
        tx_go(2'h1, 3'h1, 1'b0);
        chk("ook zero", tbl[0], pa_level_o);
        tx_bit_i <= 1'b1;
        cyc(40);
        chk("ook one", tbl[1], pa_level_o);
        tx_stop();
    endtask
    task automatic t_cal();
        cal_value_i <= 6'h15;
        cal_done_i <= 1'b1;
        @(posedge mclk_i);
        cal_done_i <= 1'b0;
        rchk("cal unlocked", 8'h03, 8'h3F);
        fork
            host.cal_until_lock(ok);
            begin
                cyc(10);
                pll_lock_i <= 1'b1;
                cal_done_i <= 1'b1;
                @(posedge mclk_i);
                cal_done_i <= 1'b0;
            end
        join
        chk("lock seen", 8'h01, {7'h00, ok});
        rchk("cal locked", 8'h03, 8'h15);
    endtask
    task automatic t_gp();
        host.wr(8'h02, 8'h0A, 1'b0);
        pll_lock_i <= 1'b0;
        cyc(3);
        chk("gp unlocked", 8'h00, {7'h00, gp_output_pin_o});
        pll_lock_i <= 1'b1;
        cyc(3);
        chk("gp locked", 8'h01, {7'h00, gp_output_pin_o});
        // Sleep stays set until select drops, so the sleep bit still reads high
        rchk("status", 8'h05, 8'h03);
        host.wr(8'h02, 8'h03, 1'b0);
        gp_other_i <= 8'h08;
        cyc(3);
        chk("gp other", 8'h01, {7'h00, gp_output_pin_o});
    endtask
    task automatic t_power();
        serial_select_n_i <= 1'b0;
        power_down_strobe_i <= 1'b1;
        @(posedge mclk_i);
        power_down_strobe_i <= 1'b0;
        cyc(4);
        chk("power held", 8'h01, {7'h00, core_power_on_o});
        serial_select_n_i <= 1'b1;
        cyc(6);
        chk("power off", 8'h00, {7'h00, core_power_on_o});
        serial_select_n_i <= 1'b0;
        cyc(6);
        chk("power back", 8'h03, {6'h00, core_power_on_o, xosc_enable_o});
    endtask
    initial begin
        {resetn_i, serial_select_n_i, power_down_strobe_i, sleep_req_i} = 4'b0100;
        {tx_start_i, tx_end_i, tx_bit_i, pll_lock_i, cal_done_i} = 5'b00000;
        cal_value_i = 6'h00;
        gp_other_i = 8'h00;
        for (int i = 0; i < 8; i++) tbl[i] = patr_pkg::POWER_TABLE_RST;
        cyc(4);
        resetn_i <= 1'b1;
        rchk("table default", 8'h00, 8'hC6);
        host.wr(8'h7E, 8'h55, 1'b0);
        rchk("unmapped", 8'h7E, 8'h00);
        host.wr(8'h04, 8'h03, 1'b0);
        for (int i = 0; i < 8; i++) tbl[i] = 8'h10 + 8'(i);
        for (int i = 0; i < 8; i++) host.wr(8'h00, tbl[i], 1'b1);
        host.end_burst();
        tbl[0] = 8'h20;
        host.wr(8'h00, tbl[0], 1'b0);
        rchk("entry zero", 8'h00, tbl[0]);
        t_ramp(2'h0, 3'h3);
        t_ramp(2'h0, 3'h0);
        t_ramp(2'h2, 3'h7);
        t_ook();
        t_cal();
        sleep_req_i <= 1'b1;
        cyc(4);
        sleep_req_i <= 1'b0;
        // Lock lost while asleep must not wipe the kept calibration word
        pll_lock_i <= 1'b0;
        cyc(2);
        for (int i = 1; i < 8; i++) tbl[i] = patr_pkg::POWER_TABLE_RST;
        rchk("kept entry", 8'h00, 8'h20);
        rchk("kept cal", 8'h03, 8'h15);
        t_ook();
        t_gp();
        t_power();
        print_verdict();
    end
endmodule
bind patr_ctrl patr_ctrl_chk u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_select_n_i(serial_select_n_i),
    .power_down_strobe_i(power_down_strobe_i), .core_power_on_o(core_power_on_o),
    .xosc_enable_o(xosc_enable_o), .tx_start_i(tx_start_i), .tx_active_o(tx_active_o),
    .pa_level_o(pa_level_o), .pll_lock_i(pll_lock_i), .cal_done_i(cal_done_i),
    .gp_output_pin_o(gp_output_pin_o));
`default_nettype wire
